// File: logic/mtr_responder.sv
// telegram responder: takes a 16-byte request from the head module's output
// area and builds the 16-byte response for its input area
// assumes request bytes are stable while the head module owns them and that
// the measurement side commits values and the current tag itself
//
// Behaviour
// - every telegram is sixteen bytes, four header then twelve data
// - byte zero holds status low nibble, type bits 6..4, bit 7 zero
// - byte one holds the measurand identifier, valid 1 to 41
// - byte two holds dataset tag 1..15 low, length 0..12 high
// - only the stated number of user bytes are meaningful
// - on failure send no data, length zero, error code in status
// - codes 0 ok, 1 refresh, 2 tag, 3 length, 4 big, 5 undefined
// - codes 6 measurand, 7 command, 8 definition, 9 type, a, e, f
// - with several errors report the highest code
// - byte three summarises seven limit violations, bit 7 reserved
// - request read from output area, answer may lag several cycles
// - values of one measurement share a single dataset tag
// - types 0 zero, 1 value, 2 frame, 3 define, 4 command, 6 param
// - response echoes measurand identifier and dataset tag of request
`timescale 1ns/10ps
module mtr_responder
    import mtr_pkg::*;
#(
    parameter int SLOTS = 42
)
(
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // head module output area (request)
    input  wire mtr_telegram_type request,
    // head module input area (response)
    output mtr_telegram_type      response,
    output logic                  response_valid,
    // measurement side: commits one measurand's value under a tag
    input  wire logic             meas_wr,
    input  wire logic [5:0]       meas_id,
    input  wire logic [USER_BYTES*8-1:0] meas_data,
    input  wire logic [3:0]       meas_len,
    input  wire logic [3:0]       meas_tag,
    input  wire logic             meas_available,
    // error sources from the rest of the module
    input  wire logic             refresh_fail,
    input  wire logic             transient_fail,
    input  wire logic             external_fail,
    input  wire logic             frame_big,
    input  wire logic             frame_undefined,
    input  wire logic             frame_def_bad,
    input  wire logic             command_fail,
    input  wire logic             param_bad,
    // limit summary
    input  wire mtr_limits_type   limits
);
    typedef enum logic [1:0] {
        MTR_IDLE,
        MTR_FETCH,
        MTR_BUILD
    } mtr_state_type;

    typedef struct packed {
        mtr_state_type    state;
        mtr_telegram_type last_req;
        logic             seen;
        mtr_telegram_type resp;
        logic             valid;
    } mtr_regs_type;

    mtr_regs_type r;
    mtr_regs_type next_r;

    logic [ERR_BITS-1:0]     err_flags;
    logic [3:0]              err_code;
    logic [USER_BYTES*8-1:0] rd_data;
    logic [3:0]              rd_len;
    logic [3:0]              rd_tag;
    logic [7:0]              common;

    // zero every user byte at or above the given length
    function automatic logic [USER_BYTES*8-1:0] mask_user(
        input logic [USER_BYTES*8-1:0] data,
        input logic [3:0]              len
    );
        logic [USER_BYTES*8-1:0] m;
        m = '0;
        for (int b = 0; b < USER_BYTES; b++) begin
            // byte D00 sits in the top byte of the field
            if (b < int'(len)) begin
                m[(USER_BYTES-1-b)*8 +: 8] = 8'hff;
            end
        end
        return data & m;
    endfunction

    mtr_store #(
        .SLOTS (SLOTS)
    ) u_store (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .wr_en   (meas_wr),
        .wr_slot (meas_id),
        .wr_data (meas_data),
        .wr_len  (meas_len),
        .wr_tag  (meas_tag),
        .rd_slot (request.hdr.measurand[5:0]),
        .rd_data (rd_data),
        .rd_len  (rd_len),
        .rd_tag  (rd_tag)
    );

    always_comb begin
        common = 8'h00;
        common[CS_FREQ_MAX] = limits.freq_max;
        common[CS_FREQ_MIN] = limits.freq_min;
        common[CS_TEMP_MAX] = limits.temp_max;
        common[CS_VOLT_MAX] = limits.voltage_upper_limit;
        common[CS_VOLT_MIN] = limits.voltage_lower_limit;
        common[CS_POWER_FACTOR_LOWER_LIMIT]   = limits.power_factor_lower_limit;
        common[CS_CURR_MAX] = limits.current_upper_limit;
    end

    // error vector of the request held in last_req
    always_comb begin
        mtr_header_type h;
        logic is_read;
        h = r.last_req.hdr;
        is_read = (h.tel_type == TT_READ_VALUE);
        err_flags = '0;
        err_flags[ST_REFRESH]     = refresh_fail;
        err_flags[ST_TAG]         = is_read && (h.dataset_tag < TAG_MIN ||
                                    h.dataset_tag != rd_tag);
        err_flags[ST_LENGTH]      = (h.length > LEN_MAX) || h.reserved;
        err_flags[ST_FRAME_BIG]   = frame_big;
        err_flags[ST_FRAME_UNDEF] = frame_undefined;
        err_flags[ST_NO_MEAS]     = is_read && (h.measurand < {2'b00, ID_MIN}
                                    || h.measurand > {2'b00, ID_MAX}
                                    || !meas_available);
        err_flags[ST_CMD_FAIL]    = command_fail;
        err_flags[ST_FRAME_DEF]   = frame_def_bad;
        err_flags[ST_TYPE]        = !(h.tel_type inside {TT_ZERO_FRAME,
                                    TT_READ_VALUE, TT_READ_FRAME,
                                    TT_SET_FRAME, TT_COMMAND,
                                    TT_READ_PARAM});
        err_flags[ST_PARAM]       = param_bad;
        err_flags[ST_EXTERNAL]    = external_fail;
        err_flags[ST_TRANSIENT]   = transient_fail;
    end

    mtr_prio u_prio (
        .err_flags (err_flags),
        .err_code  (err_code)
    );

    always_comb begin
        mtr_header_type rh;
        logic [3:0]     len;
        next_r = r;
        rh = '0;
        len = 4'h0;
        unique case (r.state)
            MTR_IDLE: begin
                // a new telegram when it differs from the last one, or when none was seen since reset
                if (!r.seen || request != r.last_req) begin
                    next_r.last_req = request;
                    next_r.seen     = 1'b1;
                    next_r.state    = MTR_FETCH;
                end
            end
            MTR_FETCH: begin
                // store read data registered; wait one cycle
                next_r.state = MTR_BUILD;
            end
            MTR_BUILD: begin
                rh.reserved    = 1'b0;
                rh.tel_type    = r.last_req.hdr.tel_type;
                rh.measurand   = r.last_req.hdr.measurand;
                rh.dataset_tag = r.last_req.hdr.dataset_tag;
                rh.common      = common;
                rh.status      = err_code;
                if (err_code != ST_OK) begin
                    len = 4'h0;
                end else if (r.last_req.hdr.tel_type == TT_READ_VALUE) begin
                    len = (rd_len > LEN_MAX) ? LEN_MAX : rd_len;
                end else begin
                    len = 4'h0;
                end
                rh.length = len;
                next_r.resp.hdr  = rh;
                next_r.resp.user = mask_user(rd_data, len);
                next_r.valid     = 1'b1;
                next_r.state     = MTR_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r <= '{state: MTR_IDLE, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign response       = r.resp;
    assign response_valid = r.valid;
endmodule

// File: logic/mtr_pkg.sv
// package of the measurement telegram responder: layouts, codes, limits
// assumes one 100 MHz processing clock shared by all users
package mtr_pkg;
    localparam int TEL_BYTES    = 16;
    localparam int HDR_BYTES    = 4;
    localparam int USER_BYTES   = 12;
    localparam logic [5:0] ID_MIN = 6'h01;
    localparam logic [5:0] ID_MAX = 6'h29;
    localparam logic [3:0] LEN_MAX = 4'hc;
    localparam logic [3:0] TAG_MIN = 4'h1;
    // common-status bit positions
    localparam int CS_FREQ_MAX  = 0;
    localparam int CS_FREQ_MIN  = 1;
    localparam int CS_TEMP_MAX  = 2;
    localparam int CS_VOLT_MAX  = 3;
    localparam int CS_VOLT_MIN  = 4;
    localparam int CS_POWER_FACTOR_LOWER_LIMIT    = 5;
    localparam int CS_CURR_MAX  = 6;
    // telegram type field values (bits 6..4 of header byte zero)
    localparam logic [2:0] TT_ZERO_FRAME = 3'h0;
    localparam logic [2:0] TT_READ_VALUE = 3'h1;
    localparam logic [2:0] TT_READ_FRAME = 3'h2;
    localparam logic [2:0] TT_SET_FRAME  = 3'h3;
    localparam logic [2:0] TT_COMMAND    = 3'h4;
    localparam logic [2:0] TT_READ_PARAM = 3'h6;
    // communication status codes
    localparam logic [3:0] ST_OK          = 4'h0;
    localparam logic [3:0] ST_REFRESH     = 4'h1;
    localparam logic [3:0] ST_TAG         = 4'h2;
    localparam logic [3:0] ST_LENGTH      = 4'h3;
    localparam logic [3:0] ST_FRAME_BIG   = 4'h4;
    localparam logic [3:0] ST_FRAME_UNDEF = 4'h5;
    localparam logic [3:0] ST_NO_MEAS     = 4'h6;
    localparam logic [3:0] ST_CMD_FAIL    = 4'h7;
    localparam logic [3:0] ST_FRAME_DEF   = 4'h8;
    localparam logic [3:0] ST_TYPE        = 4'h9;
    localparam logic [3:0] ST_PARAM       = 4'ha;
    localparam logic [3:0] ST_EXTERNAL    = 4'he;
    localparam logic [3:0] ST_TRANSIENT   = 4'hf;
    localparam int ERR_BITS = 16;

    typedef struct packed {
        logic       reserved;
        logic [2:0] tel_type;
        logic [3:0] status;
        logic [7:0] measurand;
        logic [3:0] length;
        logic [3:0] dataset_tag;
        logic [7:0] common;
    } mtr_header_type;

    typedef struct packed {
        mtr_header_type           hdr;
        logic [USER_BYTES*8-1:0]  user;
    } mtr_telegram_type;

    typedef struct packed {
        logic freq_max;
        logic freq_min;
        logic temp_max;
        logic voltage_upper_limit;
        logic voltage_lower_limit;
        logic power_factor_lower_limit;
        logic current_upper_limit;
    } mtr_limits_type;
endpackage

// File: logic/mtr_prio.sv
// picks the highest error code from a one-hot-per-code error vector
// assumes bit n of the vector means status code n applies
`timescale 1ns/10ps
module mtr_prio
    import mtr_pkg::*;
(
    // error flags, bit index equals code
    input  wire logic [ERR_BITS-1:0] err_flags,
    // chosen code
    output logic [3:0]               err_code
);
    always_comb begin
        err_code = ST_OK;
        for (int i = 0; i < ERR_BITS; i++) begin
            if (err_flags[i]) begin
                err_code = 4'(i);
            end
        end
    end
endmodule

// File: logic/mtr_store.sv
// value store: one 12-byte user-data slot per measurand, plus dataset tag
// assumes the writer commits a whole measurement in one pass under one tag
`timescale 1ns/10ps
module mtr_store
    import mtr_pkg::*;
#(
    parameter int SLOTS = 42
)
(
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    sys_rst,
    // write side
    input  wire logic                    wr_en,
    input  wire logic [5:0]              wr_slot,
    input  wire logic [USER_BYTES*8-1:0] wr_data,
    input  wire logic [3:0]              wr_len,
    input  wire logic [3:0]              wr_tag,
    // read side
    input  wire logic [5:0]              rd_slot,
    output logic [USER_BYTES*8-1:0]      rd_data,
    output logic [3:0]                   rd_len,
    output logic [3:0]                   rd_tag
);
    logic [USER_BYTES*8+7:0] mem [SLOTS];
    logic [USER_BYTES*8+7:0] rd_word;

    always_ff @(posedge ref_clk) begin
        if (wr_en && int'(wr_slot) < SLOTS) begin
            mem[wr_slot] <= {wr_tag, wr_len, wr_data};
        end
        if (sys_rst) begin
            rd_word <= '0;
        end else if (int'(rd_slot) < SLOTS) begin
            rd_word <= mem[rd_slot];
        end else begin
            rd_word <= '0;
        end
    end

    assign rd_tag  = rd_word[USER_BYTES*8+7 -: 4];
    assign rd_len  = rd_word[USER_BYTES*8+3 -: 4];
    assign rd_data = rd_word[USER_BYTES*8-1:0];
endmodule

// File: tb/mtr_head.sv
// head module model: places requests in its output area
// assumes the responder answers within three cycles of a take
`timescale 1ns/10ps
module mtr_head
    import mtr_pkg::*;
(
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // bench side
    input  wire logic             load,
    input  wire mtr_telegram_type next_req,
    output logic                  done,
    // output area
    output mtr_telegram_type      request
);
    logic [2:0] wait_cnt;
    // request never moves mid-answer, the answer lags several cycles
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            request  <= '0;
            wait_cnt <= 3'h0;
            done     <= 1'b0;
        end else begin
            done <= (wait_cnt == 3'h1);
            if (load) begin
                request  <= next_req;
                wait_cnt <= 3'h4;
            end else if (wait_cnt != 3'h0) begin
                wait_cnt <= wait_cnt - 3'h1;
            end
        end
    end
endmodule

// File: tb/mtr_properties.sv
// checker of response layout and timing at the responder ports
// assumes one clock domain and a bind to mtr_responder
`timescale 1ns/10ps
module mtr_properties
    import mtr_pkg::*;
(
    // clock and reset
    input wire logic             ref_clk,
    input wire logic             sys_rst,
    // telegrams
    input wire mtr_telegram_type request,
    input wire mtr_telegram_type response,
    input wire logic             response_valid,
    // side inputs
    input wire logic             transient_fail,
    input wire mtr_limits_type   limits
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_quiet; $stable(request)[*4]; endsequence
    sequence s_new; response_valid && $changed(response); endsequence
    property p_resv; response_valid |-> !response.hdr.reserved; endproperty
    property p_len; response_valid |-> response.hdr.length <= LEN_MAX;
    endproperty
    property p_err; response_valid && response.hdr.status != ST_OK
        |-> response.hdr.length == 4'h0 && response.user == '0; endproperty
    property p_tail; response_valid
        |-> (response.user << {response.hdr.length, 3'h0}) == '0; endproperty
    property p_echo; s_new |-> response.hdr.measurand ==
        request.hdr.measurand && response.hdr.dataset_tag ==
        request.hdr.dataset_tag; endproperty
    property p_common; s_new |-> response.hdr.common == {1'b0,
        limits.current_upper_limit, limits.power_factor_lower_limit,
        limits.voltage_lower_limit, limits.voltage_upper_limit,
        limits.temp_max, limits.freq_min, limits.freq_max}; endproperty
    property p_prio; (s_new and transient_fail)
        |-> response.hdr.status == ST_TRANSIENT; endproperty
    property p_hold; s_quiet |=> $stable(response); endproperty
    // the answer to a changed request carries its type, measurand and tag
    property p_first; $changed(request) |-> ##[1:3] (response_valid &&
        response.hdr.tel_type == request.hdr.tel_type &&
        response.hdr.measurand == request.hdr.measurand &&
        response.hdr.dataset_tag == request.hdr.dataset_tag); endproperty
    a_resv: assert property (p_resv) else $error("reserved set");
    a_len: assert property (p_len) else $error("length too big");
    a_err: assert property (p_err) else $error("data on error");
    a_tail: assert property (p_tail) else $error("stale bytes");
    a_echo: assert property (p_echo) else $error("no echo");
    a_common: assert property (p_common) else $error("common");
    a_prio: assert property (p_prio) else $error("priority");
    a_hold: assert property (p_hold) else $error("not held");
    a_first: assert property (p_first) else $error("late");
endmodule
bind mtr_responder mtr_properties mtr_properties_inst (.ref_clk,
    .sys_rst, .request, .response, .response_valid, .transient_fail,
    .limits);

// File: tb/tb.sv
// self-checking bench of the telegram responder
// assumes mtr_head as head module and the checker bound to the design
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t response differs", $time); end end
module tb
    import mtr_pkg::*;
;
    logic             ref_clk, sys_rst, load, done, resp_valid, meas_wr;
    logic             avail;
    logic [5:0]       meas_id;
    logic [95:0]      meas_data, md;
    logic [3:0]       meas_len, meas_tag;
    logic [7:0]       errs;
    logic [3:0]       codes [8];
    mtr_limits_type   limits;
    mtr_telegram_type next_req, request, response, exp_t, exp_q[$];
    int               n_mismatch, checked, seed, k;
    logic [2:0]       types [5];
    mtr_head mtr_head_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .load(load), .next_req(next_req), .done(done), .request(request));
    mtr_responder mtr_responder_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .request(request), .response(response), .response_valid(resp_valid),
        .meas_wr(meas_wr), .meas_id(meas_id), .meas_data(meas_data),
        .meas_len(meas_len), .meas_tag(meas_tag), .meas_available(avail),
        .refresh_fail(errs[0]), .transient_fail(errs[1]),
        .external_fail(errs[2]), .frame_big(errs[3]),
        .frame_undefined(errs[4]), .frame_def_bad(errs[5]),
        .command_fail(errs[6]), .param_bad(errs[7]), .limits(limits));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task test_done;
        $display("checked=%0d mismatches=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // request user bytes are random so every request differs from the last
    task send(input logic [2:0] tt, input logic [7:0] id,
              input logic [3:0] tag, len, input logic [7:0] er,
              input logic av, input logic [3:0] st, elen,
              input logic [95:0] eu);
        mtr_telegram_type r;
        mtr_limits_type   lim;
        int               i;
        r = '0;
        r.hdr.tel_type = tt;
        r.hdr.measurand = id;
        r.hdr.length = len;
        r.hdr.dataset_tag = tag;
        r.user = {$random(seed), $random(seed), $random(seed)};
        lim = 7'($random(seed));
        exp_t = '0;
        exp_t.hdr = r.hdr;
        exp_t.hdr.status = st;
        exp_t.hdr.length = elen;
        exp_t.user = eu;
        for (i = 0; i < 7; i++) exp_t.hdr.common[i] = lim[6-i];
        exp_q.push_back(exp_t);
        @(posedge ref_clk);
        next_req <= r;
        limits <= lim;
        errs <= er;
        avail <= av;
        load <= 1'b1;
        @(posedge ref_clk);
        load <= 1'b0;
        i = 0;
        while (done !== 1'b1 && i < 20) begin
            @(negedge ref_clk);
            i++;
        end
        if (done !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t no answer from head", $time);
        end
        @(posedge ref_clk);
    endtask
    always @(negedge ref_clk) begin
        if (done === 1'b1) begin
            `CHK(response, exp_q.pop_front())
            `CHK(resp_valid, 1'b1)
        end
    end
    initial begin
        #100000;
        n_mismatch++;
        test_done;
    end
    initial begin
        {sys_rst, load, meas_wr, avail} = 4'h9;
        {errs, limits, next_req, meas_id, meas_data} = '0;
        {meas_len, meas_tag, n_mismatch, checked} = '0;
        seed = 56718;
        codes = '{4'h1, 4'hf, 4'he, 4'h4, 4'h5, 4'h8, 4'h7, 4'ha};
        types = '{TT_ZERO_FRAME, TT_READ_FRAME, TT_SET_FRAME, TT_COMMAND,
                  TT_READ_PARAM};
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        md = {$random(seed), $random(seed), $random(seed)};
        @(posedge ref_clk);
        {meas_wr, meas_id, meas_data} <= {1'b1, 6'h0e, md};
        {meas_len, meas_tag} <= {4'h2, 4'h1};
        @(posedge ref_clk);
        meas_wr <= 1'b0;
        send(TT_READ_VALUE, 8'h0e, 4'h1, 4'h0, 8'h00, 1'b1, ST_OK, 4'h2,
             {md[95:80], 80'h0});
        $display("test read value done");
        send(TT_READ_VALUE, 8'h0e, 4'h2, 4'h0, 8'h00, 1'b1, ST_TAG, 4'h0,
             96'h0);
        send(TT_READ_VALUE, 8'h0e, 4'h0, 4'h0, 8'h00, 1'b1, ST_TAG, 4'h0,
             96'h0);
        send(TT_READ_VALUE, 8'h0e, 4'h1, 4'hd, 8'h00, 1'b1, ST_LENGTH, 4'h0,
             96'h0);
        send(TT_READ_VALUE, 8'h2a, 4'h1, 4'h0, 8'h00, 1'b1, ST_NO_MEAS, 4'h0,
             96'h0);
        send(TT_READ_VALUE, 8'h0e, 4'h1, 4'hd, 8'h00, 1'b0, ST_NO_MEAS, 4'h0,
             96'h0);
        send(3'h5, 8'h0e, 4'h1, 4'h0, 8'h00, 1'b1, ST_TYPE, 4'h0,
             96'h0);
        send(3'h7, 8'h0e, 4'h0, 4'h0, 8'h00, 1'b1, ST_TYPE, 4'h0,
             96'h0);
        $display("test refusals done");
        for (k = 0; k < 5; k++) send(types[k], 8'h0e, 4'h1, 4'h0, 8'h00,
             1'b1, ST_OK, 4'h0, 96'h0);
        for (k = 0; k < 8; k++) send(TT_READ_VALUE, 8'h0e, 4'h1, 4'h0,
             8'(1 << k), 1'b1, codes[k], 4'h0, 96'h0);
        send(TT_READ_VALUE, 8'h2a, 4'h2, 4'hd, 8'hff, 1'b1, ST_TRANSIENT,
             4'h0, 96'h0);
        $display("test error codes done");
        test_done;
    end
endmodule
